// ==== cfr_pkg.sv ====
// Package for the front-end setup register bank.
// Assumes a 32-bit AXI4-Lite bus with word-aligned register addresses.
package cfr_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam logic [7:0]  ADDR_LINE_MODE    = 8'h00;
  localparam logic [7:0]  ADDR_SAMPLE_DET   = 8'h04;
  localparam logic [7:0]  ADDR_BLOCK_PWR    = 8'h08;
  localparam logic [7:0]  ADDR_GLOBAL_CTRL  = 8'h0c;
  localparam logic [7:0]  ADDR_CYCLE_RESET  = 8'h10;
  localparam logic [7:0]  ADDR_STATUS       = 8'h14;
  localparam logic [7:0]  ADDR_RED_OFFSET   = 8'h20;
  localparam logic [7:0]  ADDR_GREEN_OFFSET = 8'h24;
  localparam logic [7:0]  ADDR_BLUE_OFFSET  = 8'h28;
  localparam logic [7:0]  ADDR_ALL_OFFSET   = 8'h2c;
  localparam logic [7:0]  ADDR_RED_GAIN     = 8'h30;
  localparam logic [7:0]  ADDR_GREEN_GAIN   = 8'h34;
  localparam logic [7:0]  ADDR_BLUE_GAIN    = 8'h38;
  localparam logic [7:0]  ADDR_ALL_GAIN     = 8'h3c;
  // Line mode control fields
  localparam int          LM_LINE_SEQ       = 0;
  localparam int          LM_AUTOCYCLE      = 1;
  localparam int          LM_FORCE_EN       = 2;
  localparam int          LM_INT_CLAMP      = 3;
  localparam int          LM_INT_COL_LO     = 4;
  localparam int          LM_FORCED_LO      = 6;
  // Sample detect fields
  localparam int          SD_DETECT_EN      = 0;
  localparam int          SD_DELAY_LO       = 1;
  localparam int          SD_POLARITY       = 4;
  // Global control fields
  localparam int          GC_SEL_PD         = 3;
  localparam logic [7:0]  RST_BYTE          = 8'h00;
  localparam logic [1:0]  COL_RED           = 2'h0;
  localparam logic [1:0]  COL_GREEN         = 2'h1;
  localparam logic [1:0]  COL_BLUE          = 2'h2;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  typedef enum logic [1:0] {CFR_IDLE, CFR_WAIT, CFR_RESP} cfr_wr_state_t;
endpackage

// ==== cfr_setup_regs.sv ====
// Setup register bank of a three-channel image-sensor front end.
// Assumes AXI4-Lite master on clk_sys; pins are asynchronous and synchronised.
// Notes on behaviour
// - line_sequential_sel bit 0: clear normal, set line-by-line; resets clear.
// - Line-by-line forces mono on, channel red, disables green/blue cells.
// - Autocycle bit ignored in normal mode; selects pin and mux roles.
// - Autocycle clear: pin clamps, muxes internal; set: pin pulses advance colour.
// - With autocycling the pin never clamps; internal_clamp_en governs clamping.
// - Force bit, line-by-line only, steers input mux from forced_input_sel.
// - Both bits set: internal_clamp_en 0 disables, 1 enables clamping.
// - internal_colour_sel bits 5:4: red, green, blue; 11 reserved.
// - forced_input_sel bits 7:6: red, green, blue input; 11 reserved.
// - Detect disabled: sample pulse passes unmodified to timing.
// - Detect enabled: chosen edge makes an internal sync pulse instead.
// - Internal pulse delayed sample_pulse_delay master clocks after the edge.
// - Polarity bit 4: 0 falling edge, 1 rising edge, detect only.
// - Disable mask acts only with selective powerdown; set bit disables.
// - Mask bit 0 red, 1 green, 2 blue cell, 3 converter.
// - Each channel has 8-bit read/write offset code, reset zero.
// - Combined offset write updates all three offset codes at once.
// - Each channel has 8-bit gain code, reset zero.
// - Combined gain write updates all three gain codes at once.
// - selective_powerdown_en bit 3 enables per-block disabling when set.
// - Any write to auto-cycle reset returns the counter to red.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
module cfr_setup_regs (
  // System
  input  wire  logic                          clk_sys,
  input  wire  logic                          nrst,
  // AXI4-Lite write address
  input  wire  logic [cfr_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire  logic                          s_axi_awvalid,
  output logic                                s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [cfr_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire  logic [3:0]                    s_axi_wstrb,
  input  wire  logic                          s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire  logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [cfr_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire  logic                          s_axi_arvalid,
  output logic                                s_axi_arready,
  // AXI4-Lite read data
  output logic [cfr_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire  logic                          s_axi_rready,
  // Pins
  input  wire  logic                          clamp_cycle_pin,
  input  wire  logic                          video_sample_pulse,
  // Front-end controls
  output logic                                timing_sample_pulse,
  output logic                                clamp_active,
  output logic                                mono_sel,
  output logic [1:0]                          mono_channel_sel,
  output logic [1:0]                          input_mux_sel,
  output logic [1:0]                          gain_offset_mux_sel,
  output logic [3:0]                          cell_disable,
  output logic [7:0]                          red_offset_code,
  output logic [7:0]                          green_offset_code,
  output logic [7:0]                          blue_offset_code,
  output logic [7:0]                          red_gain_code,
  output logic [7:0]                          green_gain_code,
  output logic [7:0]                          blue_gain_code
);
  import cfr_pkg::*;

  logic [7:0]           line_mode_control_reg;
  logic [7:0]           sample_pulse_detect_control_reg;
  logic [7:0]           block_power_disable_reg;
  logic [7:0]           global_control_reg;
  logic [7:0]           red_offset_reg;
  logic [7:0]           green_offset_reg;
  logic [7:0]           blue_offset_reg;
  logic [7:0]           red_gain_reg;
  logic [7:0]           green_gain_reg;
  logic [7:0]           blue_gain_reg;
  logic [1:0]           cycle_colour_reg;
  cfr_wr_state_t        wr_state_reg;
  logic [ADDR_W-1:0]    wr_addr_reg;
  logic [7:0]           wr_data_reg;
  logic                 wr_strb_reg;
  logic                 have_addr_reg;
  logic                 have_data_reg;
  logic                 wr_fire;
  logic                 wr_mapped;
  logic [2:0]           clamp_sync_reg;
  logic [2:0]           vsp_sync_reg;
  logic [7:0]           delay_pipe_reg;
  logic [DATA_W-1:0]    rd_value;
  logic                 rd_mapped;

  // Byte value merged with lane 0 strobe
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       strb);
    merge_byte = strb ? new_v : old_v;
  endfunction

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] target);
    wr_hit = (a[ADDR_W-1:2] == target[ADDR_W-1:2]);
  endfunction

  // Write channel: address and data accepted in either order
  assign wr_fire = (wr_state_reg == CFR_WAIT);
  always_comb begin
    wr_mapped = 1'b1;
    case (wr_addr_reg & 8'hfc)
      ADDR_LINE_MODE, ADDR_SAMPLE_DET, ADDR_BLOCK_PWR, ADDR_GLOBAL_CTRL,
      ADDR_CYCLE_RESET, ADDR_RED_OFFSET, ADDR_GREEN_OFFSET,
      ADDR_BLUE_OFFSET, ADDR_ALL_OFFSET, ADDR_RED_GAIN, ADDR_GREEN_GAIN,
      ADDR_BLUE_GAIN, ADDR_ALL_GAIN: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_state_reg  <= CFR_IDLE;
      have_addr_reg <= 1'b0;
      have_data_reg <= 1'b0;
      wr_addr_reg   <= '0;
      wr_data_reg   <= RST_BYTE;
      wr_strb_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      case (wr_state_reg)
        CFR_IDLE: begin
          s_axi_awready <= !have_addr_reg && !s_axi_awready;
          s_axi_wready  <= !have_data_reg && !s_axi_wready;
          if (s_axi_awvalid && s_axi_awready) begin
            wr_addr_reg   <= s_axi_awaddr;
            have_addr_reg <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wr_data_reg   <= s_axi_wdata[7:0];
            wr_strb_reg   <= s_axi_wstrb[0];
            have_data_reg <= 1'b1;
            s_axi_wready  <= 1'b0;
          end
          if ((have_addr_reg || (s_axi_awvalid && s_axi_awready)) &&
              (have_data_reg || (s_axi_wvalid && s_axi_wready))) begin
            wr_state_reg  <= CFR_WAIT;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
          end
        end
        CFR_WAIT: begin
          s_axi_bvalid  <= 1'b1;
          s_axi_bresp   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
          have_addr_reg <= 1'b0;
          have_data_reg <= 1'b0;
          wr_state_reg  <= CFR_RESP;
        end
        CFR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= CFR_IDLE;
          end
        end
        default: wr_state_reg <= CFR_IDLE;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      line_mode_control_reg           <= RST_BYTE;
      sample_pulse_detect_control_reg <= RST_BYTE;
      block_power_disable_reg         <= RST_BYTE;
      global_control_reg              <= RST_BYTE;
    end else if (wr_fire) begin
      if (wr_hit(wr_addr_reg, ADDR_LINE_MODE))
        line_mode_control_reg <= merge_byte(line_mode_control_reg,
                                            wr_data_reg, wr_strb_reg);
      if (wr_hit(wr_addr_reg, ADDR_SAMPLE_DET))
        sample_pulse_detect_control_reg <= merge_byte(
          sample_pulse_detect_control_reg, wr_data_reg, wr_strb_reg);
      if (wr_hit(wr_addr_reg, ADDR_BLOCK_PWR))
        block_power_disable_reg <= merge_byte(block_power_disable_reg,
                                              wr_data_reg, wr_strb_reg);
      if (wr_hit(wr_addr_reg, ADDR_GLOBAL_CTRL))
        global_control_reg <= merge_byte(global_control_reg,
                                         wr_data_reg, wr_strb_reg);
    end
  end

  // Offset codes, combined write hits all three
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      red_offset_reg   <= RST_BYTE;
      green_offset_reg <= RST_BYTE;
      blue_offset_reg  <= RST_BYTE;
    end else if (wr_fire && wr_strb_reg) begin
      if (wr_hit(wr_addr_reg, ADDR_RED_OFFSET) ||
          wr_hit(wr_addr_reg, ADDR_ALL_OFFSET))
        red_offset_reg <= wr_data_reg;
      if (wr_hit(wr_addr_reg, ADDR_GREEN_OFFSET) ||
          wr_hit(wr_addr_reg, ADDR_ALL_OFFSET))
        green_offset_reg <= wr_data_reg;
      if (wr_hit(wr_addr_reg, ADDR_BLUE_OFFSET) ||
          wr_hit(wr_addr_reg, ADDR_ALL_OFFSET))
        blue_offset_reg <= wr_data_reg;
    end
  end

  // Gain codes, combined write hits all three
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      red_gain_reg   <= RST_BYTE;
      green_gain_reg <= RST_BYTE;
      blue_gain_reg  <= RST_BYTE;
    end else if (wr_fire && wr_strb_reg) begin
      if (wr_hit(wr_addr_reg, ADDR_RED_GAIN) ||
          wr_hit(wr_addr_reg, ADDR_ALL_GAIN))
        red_gain_reg <= wr_data_reg;
      if (wr_hit(wr_addr_reg, ADDR_GREEN_GAIN) ||
          wr_hit(wr_addr_reg, ADDR_ALL_GAIN))
        green_gain_reg <= wr_data_reg;
      if (wr_hit(wr_addr_reg, ADDR_BLUE_GAIN) ||
          wr_hit(wr_addr_reg, ADDR_ALL_GAIN))
        blue_gain_reg <= wr_data_reg;
    end
  end

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clamp_sync_reg <= 3'h0;
      vsp_sync_reg   <= 3'h0;
    end else begin
      clamp_sync_reg <= {clamp_sync_reg[1:0], clamp_cycle_pin};
      vsp_sync_reg   <= {vsp_sync_reg[1:0], video_sample_pulse};
    end
  end

  // Auto-cycle counter; reset write wins over a same-cycle pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cycle_colour_reg <= COL_RED;
    end else if (wr_fire && wr_hit(wr_addr_reg, ADDR_CYCLE_RESET)) begin
      cycle_colour_reg <= COL_RED;
    end else if (line_mode_control_reg[LM_LINE_SEQ] &&
                 line_mode_control_reg[LM_AUTOCYCLE] &&
                 clamp_sync_reg[1] && !clamp_sync_reg[2]) begin
      case (cycle_colour_reg)
        COL_RED:   cycle_colour_reg <= COL_GREEN;
        COL_GREEN: cycle_colour_reg <= COL_BLUE;
        default:   cycle_colour_reg <= COL_RED;
      endcase
    end
  end

  // Sample pulse: edge detect plus delay line in master clocks
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      delay_pipe_reg <= 8'h00;
    end else begin
      delay_pipe_reg <= {delay_pipe_reg[6:0],
        sample_pulse_detect_control_reg[SD_POLARITY] ?
          (vsp_sync_reg[1] && !vsp_sync_reg[2]) :
          (!vsp_sync_reg[1] && vsp_sync_reg[2])};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timing_sample_pulse <= 1'b0;
    end else if (sample_pulse_detect_control_reg[SD_DETECT_EN]) begin
      timing_sample_pulse <= delay_pipe_reg[
        sample_pulse_detect_control_reg[SD_DELAY_LO+:3]];
    end else begin
      timing_sample_pulse <= vsp_sync_reg[1];
    end
  end

  // Derived front-end controls
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clamp_active        <= 1'b0;
      mono_sel            <= 1'b0;
      mono_channel_sel    <= COL_RED;
      input_mux_sel       <= COL_RED;
      gain_offset_mux_sel <= COL_RED;
      cell_disable        <= 4'h0;
    end else begin
      mono_sel         <= line_mode_control_reg[LM_LINE_SEQ];
      mono_channel_sel <= COL_RED;
      if (!line_mode_control_reg[LM_LINE_SEQ]) begin
        clamp_active        <= clamp_sync_reg[1];
        gain_offset_mux_sel <= line_mode_control_reg[LM_INT_COL_LO+:2];
        input_mux_sel       <= line_mode_control_reg[LM_INT_COL_LO+:2];
      end else if (line_mode_control_reg[LM_AUTOCYCLE]) begin
        clamp_active <= line_mode_control_reg[LM_INT_CLAMP];
        gain_offset_mux_sel <= cycle_colour_reg;
        input_mux_sel <= line_mode_control_reg[LM_FORCE_EN] ?
          line_mode_control_reg[LM_FORCED_LO+:2] : cycle_colour_reg;
      end else begin
        clamp_active        <= clamp_sync_reg[1];
        gain_offset_mux_sel <= line_mode_control_reg[LM_INT_COL_LO+:2];
        input_mux_sel <= line_mode_control_reg[LM_FORCE_EN] ?
          line_mode_control_reg[LM_FORCED_LO+:2] :
          line_mode_control_reg[LM_INT_COL_LO+:2];
      end
      cell_disable <= (global_control_reg[GC_SEL_PD] ?
                       block_power_disable_reg[3:0] : 4'h0) |
                      {1'b0, {2{line_mode_control_reg[LM_LINE_SEQ]}}, 1'b0};
    end
  end

  assign red_offset_code   = red_offset_reg;
  assign green_offset_code = green_offset_reg;
  assign blue_offset_code  = blue_offset_reg;
  assign red_gain_code     = red_gain_reg;
  assign green_gain_code   = green_gain_reg;
  assign blue_gain_code    = blue_gain_reg;

  // Read mux; status shows live colour and outputs
  always_comb begin
    rd_value  = '0;
    rd_mapped = 1'b1;
    case (s_axi_araddr & 8'hfc)
      ADDR_LINE_MODE:    rd_value[7:0] = line_mode_control_reg;
      ADDR_SAMPLE_DET:   rd_value[7:0] = sample_pulse_detect_control_reg;
      ADDR_BLOCK_PWR:    rd_value[7:0] = block_power_disable_reg;
      ADDR_GLOBAL_CTRL:  rd_value[7:0] = global_control_reg;
      ADDR_CYCLE_RESET:  rd_value      = '0;
      ADDR_STATUS:       rd_value[7:0] = {cell_disable, input_mux_sel,
                                          cycle_colour_reg};
      ADDR_RED_OFFSET:   rd_value[7:0] = red_offset_reg;
      ADDR_GREEN_OFFSET: rd_value[7:0] = green_offset_reg;
      ADDR_BLUE_OFFSET:  rd_value[7:0] = blue_offset_reg;
      ADDR_ALL_OFFSET:   rd_value      = '0;
      ADDR_RED_GAIN:     rd_value[7:0] = red_gain_reg;
      ADDR_GREEN_GAIN:   rd_value[7:0] = green_gain_reg;
      ADDR_BLUE_GAIN:    rd_value[7:0] = blue_gain_reg;
      ADDR_ALL_GAIN:     rd_value      = '0;
      default:           rd_mapped     = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule // cfr_setup_regs

// ==== cfr_setup_regs_properties.sv ====
// Checker for the setup register bank, bound to its top ports.
// Shadows accepted control writes.
module cfr_setup_regs_chk
  import cfr_pkg::*;
(
  // System
  input wire logic                       clk_sys,
  input wire logic                       nrst,
  // Write bus
  input wire logic [cfr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic [cfr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0]                 s_axi_wstrb,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  // Pins and controls
  input wire logic                       video_sample_pulse,
  input wire logic                       timing_sample_pulse,
  input wire logic                       mono_sel,
  input wire logic [1:0]                 mono_channel_sel,
  input wire logic [3:0]                 cell_disable,
  input wire logic [7:0]                 red_offset_code,
  input wire logic [7:0]                 green_offset_code,
  input wire logic [7:0]                 blue_offset_code,
  input wire logic [7:0]                 red_gain_code,
  input wire logic [7:0]                 green_gain_code,
  input wire logic [7:0]                 blue_gain_code
);
  logic [7:0] wa_reg, wd_reg, lm_reg, det_reg;
  logic       wok_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {wa_reg, wd_reg, lm_reg, det_reg, wok_reg} <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wd_reg  <= s_axi_wdata[7:0];
        wok_reg <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready && wok_reg) begin
        if (wa_reg == ADDR_LINE_MODE) lm_reg <= wd_reg;
        if (wa_reg == ADDR_SAMPLE_DET) det_reg <= wd_reg;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_CH_RED: assert property (mono_channel_sel == 2'h0)
    else $error("mono channel not red");
  AST_MONO_CELLS: assert property (
    mono_sel |-> cell_disable[2:1] == 2'h3)
    else $error("green and blue cells on in line mode");
  AST_RST_ZERO: assert property (
    $rose(nrst) |-> {red_offset_code, green_offset_code, blue_offset_code,
      red_gain_code, green_gain_code, blue_gain_code} == 48'h0)
    else $error("codes not zero after reset");
  AST_BC_OFFSET: assert property (
    $rose(s_axi_bvalid) && wok_reg && wa_reg == ADDR_ALL_OFFSET |=>
      red_offset_code == wd_reg && green_offset_code == wd_reg &&
      blue_offset_code == wd_reg)
    else $error("offset broadcast missed a channel");
  AST_BC_GAIN: assert property (
    $rose(s_axi_bvalid) && wok_reg && wa_reg == ADDR_ALL_GAIN |=>
      red_gain_code == wd_reg && green_gain_code == wd_reg &&
      blue_gain_code == wd_reg)
    else $error("gain broadcast missed a channel");
  AST_MONO_FOLLOW: assert property (
    lm_reg == $past(lm_reg, 3) |-> mono_sel == lm_reg[0])
    else $error("mono select differs from line mode");
  AST_PASS_THRU: assert property (
    !det_reg[0] && !$past(det_reg[0], 4) |->
      timing_sample_pulse == $past(video_sample_pulse, 3))
    else $error("sample pulse not passed through");
  AST_DET_ONE: assert property (
    det_reg[0] && timing_sample_pulse |=> !timing_sample_pulse)
    else $error("detected pulse longer than one cycle");
endmodule // cfr_setup_regs_chk

bind cfr_setup_regs cfr_setup_regs_chk chk (.*);

// ==== cfr_scan_model.sv ====
// Scanner controller side: drives the clamp/cycle and sample pins.
// Assumes callers invoke its tasks; pins change just after clk_sys rises.
module cfr_scan_model (
  // System
  input wire logic clk_sys,
  // Pins
  output logic     clamp_cycle_pin,
  output logic     video_sample_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    clamp_cycle_pin    = 1'b0;
    video_sample_pulse = 1'b0;
  end
  task automatic set_clamp(input logic v);
    @(posedge clk_sys);
    clamp_cycle_pin <= v;
  endtask
  // high for hold + 1 cycles, then low for hold cycles
  task automatic clamp_pulse(input int hold);
    set_clamp(1'b1);
    repeat (hold) @(posedge clk_sys);
    set_clamp(1'b0);
    repeat (hold) @(posedge clk_sys);
  endtask
  task automatic set_video(input logic v);
    @(posedge clk_sys);
    video_sample_pulse <= v;
  endtask
endmodule // cfr_scan_model

// ==== cfr_setup_regs_tb.sv ====
// Self-checking bench for the setup register bank.
// Drives AXI4-Lite and pins via the scan model.
module cfr_setup_regs_tb import cfr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic        tsp, clmp, mono, cpin, vsp;
  logic [7:0]  awa, ara, ro, go, bo, rg, gg, bg;
  logic [31:0] wd, rd;
  logic [3:0]  stb, cdis;
  logic [1:0]  br, rr, mch, imx, gmx;
  int          num_errors, cmp_count;
  cfr_setup_regs uut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(stb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .clamp_cycle_pin(cpin), .video_sample_pulse(vsp),
    .timing_sample_pulse(tsp), .clamp_active(clmp), .mono_sel(mono),
    .mono_channel_sel(mch), .input_mux_sel(imx), .gain_offset_mux_sel(gmx),
    .cell_disable(cdis), .red_offset_code(ro), .green_offset_code(go),
    .blue_offset_code(bo), .red_gain_code(rg), .green_gain_code(gg),
    .blue_gain_code(bg));
  cfr_scan_model model (.clk_sys(clk_sys), .clamp_cycle_pin(cpin),
    .video_sample_pulse(vsp));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [3:0] exp_cells(input logic sel, line,
                                           input logic [3:0] m);
    return (sel ? m : 4'h0) | (line ? 4'h6 : 4'h0);
  endfunction
  function automatic int exp_delay(input logic [2:0] d);
    return 4 + int'(d);
  endfunction
  task automatic chk(input logic [31:0] g, e, input string what);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    awa <= a;
    wd  <= d;
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge clk_sys);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && n < 40);
    bry <= 1'b0;
    chk(32'(n < 40), 32'h1, "write wait");
    chk(br, er, "bresp");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    ara <= a;
    {arv, rry} <= 2'h3;
    do begin
      @(posedge clk_sys);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 40);
    rry <= 1'b0;
    chk(32'(n < 40), 32'h1, "read wait");
    chk(rd, e, "rdata");
    chk(rr, er, "rresp");
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // First high and high count, 12 cycles
  task automatic edge_meas(input logic v, output int first, hi);
    first = 0;
    hi = 0;
    model.set_video(v);
    for (int m = 1; m <= 12; m++) begin
      @(posedge clk_sys);
      #1;
      if (tsp === 1'b1) begin
        hi++;
        if (first == 0) first = m;
      end
    end
  endtask
  localparam logic [7:0] RST_A [9] = '{ADDR_LINE_MODE, ADDR_SAMPLE_DET,
    ADDR_BLOCK_PWR, ADDR_RED_OFFSET, ADDR_GREEN_OFFSET, ADDR_BLUE_OFFSET,
    ADDR_RED_GAIN, ADDR_GREEN_GAIN, ADDR_BLUE_GAIN};
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  initial begin
    int f, h;
    logic [7:0] v;
    logic [3:0] m;
    {clk_sys, nrst, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    stb = 4'hf;
    void'($urandom(82081));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (RST_A[i]) rd_chk(RST_A[i], 32'h0, RESP_OKAY);
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h44, 32'h0, RESP_SLVERR);
    for (int i = 3; i < 9; i++) begin
      v = 8'($urandom);
      wr(RST_A[i], {24'($urandom), v}, RESP_OKAY);
      rd_chk(RST_A[i], {24'h0, v}, RESP_OKAY);
    end
    stb = 4'h0;
    wr(ADDR_BLUE_GAIN, 32'h0, RESP_OKAY);
    stb = 4'hf;
    rd_chk(ADDR_BLUE_GAIN, {24'h0, v}, RESP_OKAY);
    for (int b = 0; b < 2; b++) begin
      v = 8'($urandom);
      wr(ADDR_ALL_OFFSET + 8'(b * 16), 32'(v), RESP_OKAY);
      for (int i = 0; i < 4; i++)
        rd_chk(ADDR_RED_OFFSET + 8'(b * 16 + i * 4),
               i < 3 ? {24'h0, v} : 32'h0, RESP_OKAY);
    end
    m = 4'($urandom);
    wr(ADDR_BLOCK_PWR, {28'h0, m}, RESP_OKAY);
    settle();
    chk(cdis, exp_cells(1'b0, 1'b0, m), "pd");
    wr(ADDR_GLOBAL_CTRL, 32'h8, RESP_OKAY);
    settle();
    chk(cdis, exp_cells(1'b1, 1'b0, m), "pd");
    for (int k = 0; k < 6; k++) begin
      f = k % 3;
      h = k < 3 ? f : (f + 1) % 3;
      wr(ADDR_LINE_MODE, 32'(1 + 4 * (k / 3) + h * 16 + f * 64), RESP_OKAY);
      settle();
      chk({imx, gmx}, 32'(f * 4 + h), "mux");
      chk({mono,mch,cdis}, {3'h4, exp_cells(1'b1, 1'b1, m)}, "l");
    end
    model.set_clamp(1'b1);
    wr(ADDR_LINE_MODE, 32'h3, RESP_OKAY);
    settle();
    chk(clmp, 1'b0, "clamp");
    wr(ADDR_LINE_MODE, 32'hb, RESP_OKAY);
    settle();
    chk(clmp, 1'b1, "clamp");
    wr(ADDR_LINE_MODE, 32'h1, RESP_OKAY);
    settle();
    chk(clmp, 1'b1, "clamp");
    model.set_clamp(1'b0);
    settle();
    chk(clmp, 1'b0, "clamp");
    wr(ADDR_LINE_MODE, 32'h3, RESP_OKAY);
    wr(ADDR_CYCLE_RESET, $urandom, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      rd_chk(ADDR_STATUS, {24'h0, exp_cells(1'b1, 1'b1, m), 2'(i % 3),
             2'(i % 3)}, RESP_OKAY);
      model.clamp_pulse(2 + i);
    end
    wr(ADDR_CYCLE_RESET, 32'h0, RESP_OKAY);
    rd_chk(ADDR_STATUS, {24'h0, exp_cells(1'b1, 1'b1, m), 4'h0},
           RESP_OKAY);
    edge_meas(1'b1, f, h);
    chk(f, 3, "pass");
    edge_meas(1'b0, f, h);
    chk(h, 2, "pass");
    for (int k = 0; k < 4; k++) begin
      v = {3'h0, 1'(k % 2), 3'(k == 0 ? 0 : k == 1 ? 7 : $urandom), 1'b1};
      wr(ADDR_SAMPLE_DET, {24'h0, v}, RESP_OKAY);
      edge_meas(1'b1, f, h);
      chk(f, v[4]?exp_delay(v[3:1]):0, "rise");
      chk(h, 32'(v[4]), "rise");
      edge_meas(1'b0, f, h);
      chk(f, v[4] ? 0 : exp_delay(v[3:1]), "fall");
      chk(h, 32'(!v[4]), "fall");
    end
    print_verdict();
  end
endmodule // cfr_setup_regs_tb
